// ==== include/drive_status_pkg.sv ====
package drive_status_pkg;

  // ----------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------
  localparam int STATUS_WIDTH = 16;
  localparam int BIT_ENABLED = 0;
  localparam int BIT_FAULT = 2;
  localparam int BIT_IN_POS = 3;
  localparam int BIT_MOVING = 4;
  localparam int BIT_JOGGING = 5;
  localparam int BIT_STOPPING = 6;
  localparam int BIT_WAIT_IN = 7;
  localparam int BIT_SAVING = 8;
  localparam int BIT_ALARM = 9;
  localparam int BIT_HOMING = 10;
  localparam int BIT_WAIT_TIME = 11;
  localparam int BIT_INIT = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // fault-class alarm positions in the alarm word
  localparam logic [15:0] FAULT_ALARM_MASK = 16'h01b9;

  // ----------------------------------------------------------------
  // reply characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_CMD0 = 8'h53;
  localparam logic [7:0] CHAR_CMD1 = 8'h43;
  localparam logic [7:0] CHAR_EQ = 8'h3d;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ALPHA = 8'h37;
  localparam logic [2:0] NIBBLE_LAST = 3'h3;

  // live drive conditions, one flag each
  typedef struct packed {
    logic enabled;
    logic in_position;
    logic moving;
    logic jogging;
    logic stopping;
    logic wait_input;
    logic saving;
    logic homing;
    logic wait_time;
    logic initializing;
  } drive_cond_t;

  // one reply character toward the serial framer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } reply_char_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD0,
    ST_CMD1,
    ST_EQ,
    ST_HEX,
    ST_END
  } reply_state_t;

endpackage

// ==== logic/motor_drive_status_word.sv ====
`timescale 1ns/100ps
// Overview of operation
// - A status query is answered with the 16-bit status word sent as hexadecimal text.
// - The word is captured in the cycle the query arrives, all true bits at once.
// - The reply is the query name, an equals sign, the hex value, then a carriage return.
// - Bit 0 is one while the motor is enabled and zero while disabled.
// - Bit 2 is one whenever a drive fault is active.
// - Bit 3 is one while the motor is at its commanded position.
// - Bit 4 is one while the motor moves.
// - Bit 5 is one while in jog mode.
// - Bit 6 is one while decelerating from a stop command.
// - Bit 7 is one while executing the wait-for-input command.
// - Bit 8 is one while parameters are saved to nonvolatile storage.
// - Bit 9 is one whenever any alarm is present, fault or not.
// - Bit 10 is one while the seek-home command runs.
// - Bit 11 is one while the timed wait command runs.
// - Bit 15 is one while initializing after power-up.
// - Only the six fault-class alarms set the fault bit, and they also disable the motor.
module motor_drive_status_word
  import drive_status_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic query_status_command_i,
  input wire drive_cond_t cond_i,
  input wire logic [15:0] alarm_word_i,
  input wire logic reply_ready_i,
  output reply_char_t reply_o,
  output logic busy_o,
  output logic [15:0] drive_condition_word_o,
  output logic motor_disable_o
);

  // ----------------------------------------------------------------
  // live status assembly
  // ----------------------------------------------------------------
  logic fault_active;
  logic [15:0] live_word;

  // only fault-class alarms count as faults
  // fault class filter
  assign fault_active = |(alarm_word_i & FAULT_ALARM_MASK);

  // bits assembled from live conditions; reserved bits stay low
  always_comb begin
    live_word = STATUS_RESET;
    live_word[BIT_ENABLED] = cond_i.enabled & ~fault_active;
    live_word[BIT_FAULT] = fault_active;
    live_word[BIT_IN_POS] = cond_i.in_position;
    live_word[BIT_MOVING] = cond_i.moving;
    live_word[BIT_JOGGING] = cond_i.jogging;
    live_word[BIT_STOPPING] = cond_i.stopping;
    live_word[BIT_WAIT_IN] = cond_i.wait_input;
    live_word[BIT_SAVING] = cond_i.saving;
    live_word[BIT_ALARM] = |alarm_word_i;
    live_word[BIT_HOMING] = cond_i.homing;
    live_word[BIT_WAIT_TIME] = cond_i.wait_time;
    live_word[BIT_INIT] = cond_i.initializing;
    live_word[14:12] = 3'h0;
    live_word[1] = 1'b0;
  end

  // fault alarms force the motor off
  // fault disables motor
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      motor_disable_o <= 1'b0;
    end else if (clk_en_i) begin
      motor_disable_o <= fault_active;
    end
  end

  // ----------------------------------------------------------------
  // reply sequencer
  // ----------------------------------------------------------------
  reply_state_t state_q;
  logic [15:0] snap_q;
  logic [2:0] nib_q;
  logic [3:0] nib_val;
  logic [7:0] hex_char;
  logic [3:0] nib_next;
  logic [7:0] hex_next;
  logic [7:0] char_q;
  logic advance;

  assign busy_o = (state_q != ST_IDLE);
  assign advance = clk_en_i & reply_ready_i;

  // digits from the top nibble down, leading zeros kept so every reply is four digits
  assign nib_val = snap_q[15:12];
  assign hex_char = (nib_val < 4'ha) ? (CHAR_ZERO + {4'h0, nib_val})
                                     : (CHAR_ALPHA + {4'h0, nib_val});

  // digit that follows once the snapshot shifts by one nibble
  assign nib_next = snap_q[11:8];
  assign hex_next = (nib_next < 4'ha) ? (CHAR_ZERO + {4'h0, nib_next})
                                      : (CHAR_ALPHA + {4'h0, nib_next});

  // snapshot held for the whole reply so text stays consistent
  // capture on query
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      snap_q <= STATUS_RESET;
    end else if (clk_en_i) begin
      if (state_q == ST_IDLE && query_status_command_i) begin
        snap_q <= live_word;
      end else if (state_q == ST_HEX && advance) begin
        snap_q <= {snap_q[11:0], 4'h0};
      end
    end
  end

  // last captured word, visible to software
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      drive_condition_word_o <= STATUS_RESET;
    end else if (clk_en_i && state_q == ST_IDLE && query_status_command_i) begin
      drive_condition_word_o <= live_word;
    end
  end

  // queries during a reply are ignored; the host waits for the reply
  // name equals value
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      nib_q <= 3'h0;
    end else if (clk_en_i) begin
      case (state_q)
        ST_IDLE: begin
          if (query_status_command_i) begin
            state_q <= ST_CMD0;
          end
        end
        ST_CMD0: begin
          if (advance) begin
            state_q <= ST_CMD1;
          end
        end
        ST_CMD1: begin
          if (advance) begin
            state_q <= ST_EQ;
            nib_q <= 3'h0;
          end
        end
        ST_EQ: begin
          if (advance) begin
            state_q <= ST_HEX;
          end
        end
        ST_HEX: begin
          if (advance) begin
            if (nib_q == NIBBLE_LAST) begin
              state_q <= ST_END;
            end
            nib_q <= nib_q + 3'h1;
          end
        end
        ST_END: begin
          if (advance) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // reply char held in a flop; loaded with the char of the state being entered
  // so the framer sees a glitch-free data bus
  // char register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      char_q <= 8'h00;
    end else if (clk_en_i) begin
      case (state_q)
        ST_IDLE: begin
          if (query_status_command_i) begin
            char_q <= CHAR_CMD0;
          end
        end
        ST_CMD0: begin
          if (advance) begin
            char_q <= CHAR_CMD1;
          end
        end
        ST_CMD1: begin
          if (advance) begin
            char_q <= CHAR_EQ;
          end
        end
        ST_EQ: begin
          if (advance) begin
            char_q <= hex_char;
          end
        end
        ST_HEX: begin
          if (advance) begin
            char_q <= (nib_q == NIBBLE_LAST) ? CHAR_CR : hex_next;
          end
        end
        default: begin
          if (advance) begin
            char_q <= 8'h00;
          end
        end
      endcase
    end
  end

  // character presented to the framer; valid only in the reply states
  always_comb begin
    reply_o.valid = 1'b1;
    reply_o.data = char_q;
    case (state_q)
      ST_CMD0, ST_CMD1, ST_EQ, ST_HEX, ST_END: begin
        reply_o.valid = 1'b1;
      end
      default: begin
        reply_o.valid = 1'b0;
        reply_o.data = 8'h00;
      end
    endcase
  end

endmodule

// ==== verification/status_word_checker.sv ====
`timescale 1ns/100ps
module status_word_checker
  import drive_status_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic query_status_command_i,
  input wire drive_cond_t cond_i,
  input wire logic [15:0] alarm_word_i,
  input wire logic reply_ready_i,
  input wire reply_char_t reply_o,
  input wire logic busy_o,
  input wire logic [15:0] drive_condition_word_o,
  input wire logic motor_disable_o
);
  // --------------------------------
  // expected word, one edge behind
  // --------------------------------
  wire take = clk_en_i && query_status_command_i && !busy_o;
  wire fault = |(alarm_word_i & FAULT_ALARM_MASK);
  wire [15:0] word = drive_condition_word_o;
  logic [15:0] live_q;
  // held one edge so the capture edge can be judged afterwards
  always_ff @(posedge core_clk_i) live_q <= {cond_i.initializing, 3'h0, cond_i.wait_time,
    cond_i.homing, |alarm_word_i, cond_i.saving, cond_i.wait_input, cond_i.stopping,
    cond_i.jogging, cond_i.moving, cond_i.in_position, fault, 1'b0, cond_i.enabled & !fault};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_first_char: assert property (take |=> busy_o && reply_o.data == CHAR_CMD0)
    else $error("bad opening char");
  chk_char_stands: assert property (reply_o.valid && !(clk_en_i && reply_ready_i)
    |=> $stable(reply_o)) else $error("char changed unaccepted");
  chk_busy_span: assert property ($rose(busy_o) |-> busy_o[*8])
    else $error("reply too short");
  chk_refused_query: assert property (busy_o |=> $stable(word))
    else $error("word changed while busy");
  chk_reserved_zero: assert property (word[14:12] == 3'h0 && !word[1])
    else $error("reserved bit set");
  chk_motion_bits: assert property (take |=> word[5:3] == live_q[5:3])
    else $error("motion bits wrong");
  chk_wait_bits: assert property (take |=> word[8:6] == live_q[8:6])
    else $error("stop wait save bits wrong");
  chk_alarm_home: assert property (take |=> word[10:9] == live_q[10:9])
    else $error("alarm or homing bit wrong");
  chk_status_high: assert property (take |=> word[15:11] == live_q[15:11])
    else $error("upper bits wrong");
  chk_fault_enable: assert property (take |=> word[2:0] == live_q[2:0])
    else $error("fault or enable wrong");
  chk_disable_late: assert property ($past(clk_en_i) && !$past(rst_i)
    |-> motor_disable_o == live_q[2]) else $error("disable wrong");
endmodule
bind motor_drive_status_word status_word_checker chk (.*);

// ==== verification/reply_sink_model.sv ====
`timescale 1ns/100ps
module reply_sink_model (
  input wire logic core_clk_i,
  input wire logic slow_i,
  output logic reply_ready_o
);
  // slow framer stalls at random so each char must stand
  initial reply_ready_o = 1'b1;
  always @(posedge core_clk_i) reply_ready_o <= !slow_i || $urandom_range(1);
endmodule

// ==== verification/motor_drive_status_word_tb_top.sv ====
`timescale 1ns/100ps
module motor_drive_status_word_tb_top;
  import drive_status_pkg::*;
  logic core_clk_i = 0, rst_i = 1, clk_en_i = 1, query_status_command_i = 0;
  logic reply_ready_i, busy_o, motor_disable_o, slow = 0;
  logic [15:0] alarm_word_i = '0, drive_condition_word_o;
  logic [7:0] e;
  drive_cond_t cond_i = '0;
  reply_char_t reply_o;
  logic [7:0] exp_q[$];
  int err_total = 0, num_checks = 0;
  always #20 core_clk_i = ~core_clk_i;
  motor_drive_status_word dut (.*);
  reply_sink_model host (.core_clk_i(core_clk_i), .slow_i(slow), .reply_ready_o(reply_ready_i));
  // random freeze cycles; never during reset
  always @(posedge core_clk_i) clk_en_i <= rst_i | ($urandom_range(3) != 0);
  // -------------------------------
  // query driver, notes the reply
  // -------------------------------
  task automatic ask(input drive_cond_t c, input logic [15:0] a);
    logic f;
    logic [15:0] w;
    f = |(a & FAULT_ALARM_MASK);
    w = {c.initializing, 3'h0, c.wait_time, c.homing, |a, c.saving, c.wait_input,
      c.stopping, c.jogging, c.moving, c.in_position, f, 1'b0, c.enabled & !f};
    exp_q.push_back(CHAR_CMD0);
    exp_q.push_back(CHAR_CMD1);
    exp_q.push_back(CHAR_EQ);
    for (int k = 3; k >= 0; k--) begin
      exp_q.push_back(w[4*k+:4] + (w[4*k+:4] > 4'h9 ? CHAR_ALPHA : CHAR_ZERO));
    end
    exp_q.push_back(CHAR_CR);
    @(posedge core_clk_i);
    cond_i <= c;
    alarm_word_i <= a;
    query_status_command_i <= 1'b1;
    do @(negedge core_clk_i); while (!busy_o);
    // held one more edge so a query during busy is refused
    @(posedge core_clk_i);
    query_status_command_i <= 1'b0;
    // live inputs move on; the reply must keep the captured word
    cond_i <= drive_cond_t'($urandom);
    alarm_word_i <= 16'($urandom);
    do @(negedge core_clk_i); while (busy_o);
  endtask
  // accepted chars against the oldest note
  always @(posedge core_clk_i) begin
    if (!rst_i && clk_en_i && reply_ready_i && reply_o.valid === 1'b1) begin
      num_checks++;
      if (exp_q.size() == 0) begin
        err_total++;
        $display("wrong value at %0t: got %h expected %h", $time, reply_o.data, 8'h00);
      end else begin
        e = exp_q.pop_front();
        if (reply_o.data !== e) begin
          err_total++;
          $display("wrong value at %0t: got %h expected %h", $time, reply_o.data, e);
        end
      end
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk_i);
    err_total++;
    final_report;
  end
  initial begin
    void'($urandom(32'hed0a5e8f));
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // each alarm position alone with the motor commanded on
    for (int i = 0; i < 16; i++) ask(10'h3ff, 16'h0001 << i);
    slow <= 1'b1;
    repeat (24) ask(10'($urandom), 16'($urandom));
    if (exp_q.size() != 0) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, exp_q.size(), 0);
    end
    final_report;
  end
endmodule
